// ===== rtl/efpec_ctrl.sv
// embedded flash program/erase control: register file, latches and array drive
// assumes core memory bus with one-cycle select pulse, read data valid two cycles after the select
// and an array macro that returns read data combinationally on arr_rdata

////////////////////////////////////////////////////////////////////////////////

module efpec_ctrl
  import efpec_pkg::*;
#(
  parameter int unsigned SEGS = SEG_N
)
(
  input  wire logic                 core_clk,
  input  wire logic                 srst,
  input  wire efpec_bus_req_t       bus_req,
  input  wire logic                 io_out_stb,
  input  wire logic                 io_in_stb,
  input  wire logic [15:0]          io_addr,
  input  wire logic                 abort_execution,
  input  wire logic [DATA_W-1:0]    arr_rdata,
  output logic [DATA_W-1:0]         bus_rdata_q,
  output logic                      reg_mode_q,
  output efpec_array_ctl_t          arr_ctl_q,
  output logic                      arr_rd_q,
  output logic [ADDR_W-1:0]         arr_addr_q,
  output logic [ADDR_W-1:0]         latched_write_address_q,
  output logic [DATA_W-1:0]         latched_write_data_q
);

  logic [15:0]       segment_control_q;
  logic [15:0]       segment_control_d;
  logic [4:0]        test_control_q;
  logic              exec;
  logic              key_ok;
  logic [1:0]        op;
  logic              reg_wr;
  logic              arr_wr;
  logic              arr_rd;
  logic [DATA_W-1:0] rd_mux;
  logic              rd_reg_q;
  logic [1:0]        rd_idx_q;
  logic [SEGS-1:0]   seg_sel;
  logic              start_ok;
  efpec_array_ctl_t  arr_ctl_d;
  logic [1:0]        ver;
  logic              write_clean;
  logic              sel_segctl;
  logic              sel_wr_addr;
  logic              sel_wr_data;

  ////////////////////////////////////////////////////////////////////////////////
  // access mode

  efpec_mode_sw u_mode
  (
    .core_clk   (core_clk),
    .srst       (srst),
    .io_out_stb (io_out_stb),
    .io_in_stb  (io_in_stb),
    .io_addr    (io_addr),
    .reg_mode_q (reg_mode_q)
  );

  assign exec   = segment_control_q[EXE_BIT];
  assign op     = segment_control_q[OP_LO+1:OP_LO];
  assign ver    = segment_control_q[VER_LO+1:VER_LO];
  assign reg_wr = bus_req.sel && bus_req.wr && reg_mode_q;
  // array accesses are dropped while executing
  assign arr_wr = bus_req.sel && bus_req.wr && !reg_mode_q && !exec;
  assign arr_rd = bus_req.sel && !bus_req.wr && !reg_mode_q && !exec;

  ////////////////////////////////////////////////////////////////////////////////
  // register select: the four registers repeat every four words of the range

  always_comb
  begin
    sel_segctl  = 1'b0;
    sel_wr_addr = 1'b0;
    sel_wr_data = 1'b0;
    if (bus_req.addr[1:0] == REG_SEGMENT_CONTROL)
      sel_segctl = 1'b1;
    else if (bus_req.addr[1:0] == REG_LATCHED_ADDR)
      sel_wr_addr = 1'b1;
    else if (bus_req.addr[1:0] == REG_LATCHED_DATA)
      sel_wr_data = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // segment control register

  always_comb
  begin
    segment_control_d = segment_control_q;
    if (reg_wr && sel_segctl)
    begin
      // operation bits always accept writes; execute needs the key to rise
      segment_control_d[OP_LO+1:OP_LO] = bus_req.wdata[OP_LO+1:OP_LO];
      if (!exec)
      begin
        // segments and verify only move while idle
        segment_control_d[15:SEG_LO]         = bus_req.wdata[15:SEG_LO];
        segment_control_d[VER_LO+1:VER_LO]   = bus_req.wdata[VER_LO+1:VER_LO];
      end
      // key is a write-time qualifier, never stored as readable state
      segment_control_d[KEY_HIGH_POS]    = 1'b0;
      segment_control_d[KEY_LOW_POS]     = 1'b0;
      segment_control_d[RSVD_POS]        = 1'b0;
      // execute only rises with key 1 0 in the same access
      if (bus_req.wdata[EXE_BIT] && !exec)
      begin
        segment_control_d[EXE_BIT] = key_ok;
      end
      else
      begin
        segment_control_d[EXE_BIT] = bus_req.wdata[EXE_BIT];
      end
    end
  end

  assign key_ok = bus_req.wdata[KEY_HIGH_POS] && !bus_req.wdata[KEY_LOW_POS];

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      segment_control_q <= SEGCTL_RESET;
    end
    else
    begin
      segment_control_q <= segment_control_d;
    end
  end

  // test register is reserved; held only so its slot has a defined value
  always_ff @(posedge core_clk)
  begin
    if (srst)
      test_control_q <= TEST_RESET;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // write address and data latches

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      latched_write_address_q <= '0;
      latched_write_data_q    <= '0;
    end
    else if (!exec)
    begin
      if (arr_wr)
      begin
        latched_write_address_q <= bus_req.addr;
        latched_write_data_q    <= bus_req.wdata;
      end
      else if (reg_wr && sel_wr_addr)
        latched_write_address_q <= bus_req.wdata;
      else if (reg_wr && sel_wr_data)
        latched_write_data_q <= bus_req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // array drive

  // one enable per segment; a cleared bit keeps that segment out of every operation
  for (genvar g = 0; g < SEGS; g++)
  begin : g_seg
    assign seg_sel[g] = segment_control_q[SEG_LO+g];
  end
  // key was checked when execute rose; it is not stored
  assign start_ok = exec && !abort_execution && (seg_sel != '0);
  // a write under a margin read mode would program against the wrong sense level
  assign write_clean = (ver == EFPEC_READ_NORMAL);

  always_comb
  begin
    arr_ctl_d             = '0;
    arr_ctl_d.read_mode   = efpec_read_mode_t'(ver);
    arr_ctl_d.seg_en      = seg_sel;
    if (start_ok)
    begin
      // op code 00 drives nothing
      if (op == OP_ERASE)
      begin
        arr_ctl_d.erase = (latched_write_data_q == ERASE_DATA);
      end
      else if (op == OP_WRITE)
      begin
        arr_ctl_d.write = write_clean;
      end
      else if (op == OP_FLASH_WRITE)
      begin
        arr_ctl_d.flash_write = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      arr_ctl_q <= '0;
    else
      arr_ctl_q <= arr_ctl_d;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      arr_rd_q   <= 1'b0;
      arr_addr_q <= '0;
    end
    else
    begin
      arr_rd_q <= arr_rd;
      if (arr_rd)
        arr_addr_q <= bus_req.addr;
      else if (exec)
        arr_addr_q <= latched_write_address_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read path

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      rd_reg_q <= 1'b0;
      rd_idx_q <= 2'h0;
    end
    else
    begin
      rd_reg_q <= bus_req.sel && !bus_req.wr && reg_mode_q;
      rd_idx_q <= bus_req.addr[1:0];
    end
  end

  always_comb
  begin
    rd_mux = '0;
    if (rd_reg_q)
    begin
      if (rd_idx_q == REG_SEGMENT_CONTROL)
      begin
        rd_mux = segment_control_q;
      end
      else if (rd_idx_q == REG_TEST_CONTROL)
      begin
        rd_mux = {11'h000, test_control_q};
      end
      else if (rd_idx_q == REG_LATCHED_ADDR)
      begin
        rd_mux = latched_write_address_q;
      end
      else
      begin
        rd_mux = latched_write_data_q;
      end
    end
    // array data is taken from the macro one cycle after the strobe
    else if (arr_rd_q)
    begin
      rd_mux = arr_rdata;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      bus_rdata_q <= '0;
    else
      bus_rdata_q <= rd_mux;
  end

endmodule : efpec_ctrl

// ===== rtl/efpec_pkg.sv
// package for the embedded flash program/erase control block
// assumes a 16-bit core memory bus and a single core clock domain
package efpec_pkg;

  localparam int unsigned DATA_W         = 16;
  localparam int unsigned ADDR_W         = 16;
  localparam int unsigned SEG_N          = 8;

  // register indices, selected by the two lowest address bits
  localparam logic [1:0]  REG_SEGMENT_CONTROL = 2'h0;
  localparam logic [1:0]  REG_TEST_CONTROL    = 2'h1;
  localparam logic [1:0]  REG_LATCHED_ADDR    = 2'h2;
  localparam logic [1:0]  REG_LATCHED_DATA    = 2'h3;

  // mode switch port
  localparam logic [15:0] MODE_PORT      = 16'hFF0F;

  // segment control field positions
  localparam int unsigned EXE_BIT        = 0;
  localparam int unsigned OP_LO          = 1;
  localparam int unsigned VER_LO         = 3;
  localparam int unsigned KEY_LOW_POS    = 5;
  localparam int unsigned KEY_HIGH_POS   = 6;
  localparam int unsigned RSVD_POS       = 7;
  localparam int unsigned SEG_LO         = 8;

  localparam logic [15:0] SEGCTL_RESET   = 16'h0000;
  localparam logic [15:0] ERASE_DATA     = 16'hFFFF;
  localparam logic [4:0]  TEST_RESET     = 5'h00;

  // operation field codes
  localparam logic [1:0]  OP_UNDEF       = 2'h0;
  localparam logic [1:0]  OP_ERASE       = 2'h1;
  localparam logic [1:0]  OP_WRITE       = 2'h2;
  localparam logic [1:0]  OP_FLASH_WRITE = 2'h3;

  // verify field codes
  typedef enum logic [1:0] {
    EFPEC_READ_NORMAL  = 2'h0,
    EFPEC_READ_ONES    = 2'h1,
    EFPEC_READ_ZEROS   = 2'h2,
    EFPEC_READ_INVERSE = 2'h3
  } efpec_read_mode_t;

  // pulse timings kept for reference by software drivers and the bench
  localparam int unsigned CLK_HZ            = 50_000_000;
  localparam int unsigned ERASE_PULSE_US    = 5000;
  localparam int unsigned WRITE_PULSE_US    = 100;
  localparam int unsigned ERASE_PULSE_CYC   = ERASE_PULSE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned WRITE_PULSE_CYC   = WRITE_PULSE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DEPLETION_WORDS   = 32;

  // memory-bus request from the core
  typedef struct packed {
    logic              sel;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } efpec_bus_req_t;

  // drive to the analog array
  typedef struct packed {
    logic             erase;
    logic             write;
    logic             flash_write;
    logic [SEG_N-1:0] seg_en;
    efpec_read_mode_t read_mode;
  } efpec_array_ctl_t;

endpackage : efpec_pkg

// ===== rtl/efpec_mode_sw.sv
// register/array access mode switch driven by core port commands
// assumes io strobes are single-cycle pulses on core_clk
module efpec_mode_sw
  import efpec_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        io_out_stb,
  input  wire logic        io_in_stb,
  input  wire logic [15:0] io_addr,
  output logic             reg_mode_q
);

  logic reg_mode_d;

  always_comb
  begin
    reg_mode_d = reg_mode_q;
    if (io_out_stb && io_addr == MODE_PORT)
    begin
      reg_mode_d = 1'b1;
    end
    else if (io_in_stb && io_addr == MODE_PORT)
    begin
      reg_mode_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      reg_mode_q <= 1'b0;
    else
      reg_mode_q <= reg_mode_d;
  end

endmodule : efpec_mode_sw

// ===== test/efpec_ctrl_asserts.sv
// port checker for efpec_ctrl
// assumes bind onto efpec_ctrl, one core clock, sync reset
module efpec_ctrl_asserts
  import efpec_pkg::*;
#(
  parameter int unsigned SEGS = SEG_N
)
(
  input wire logic              core_clk,
  input wire logic              srst,
  input wire efpec_bus_req_t    bus_req,
  input wire logic              io_out_stb,
  input wire logic              io_in_stb,
  input wire logic [15:0]       io_addr,
  input wire logic              abort_execution,
  input wire logic [DATA_W-1:0] arr_rdata,
  input wire logic [DATA_W-1:0] bus_rdata_q,
  input wire logic              reg_mode_q,
  input wire efpec_array_ctl_t  arr_ctl_q,
  input wire logic              arr_rd_q,
  input wire logic [ADDR_W-1:0] arr_addr_q,
  input wire logic [ADDR_W-1:0] latched_write_address_q,
  input wire logic [DATA_W-1:0] latched_write_data_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  logic drv;
  logic rd_req;
  logic hit;
  assign drv    = arr_ctl_q.erase | arr_ctl_q.write | arr_ctl_q.flash_write;
  assign rd_req = bus_req.sel & ~bus_req.wr & reg_mode_q;
  assign hit    = (io_out_stb | io_in_stb) & (io_addr == MODE_PORT);
  ////////////////////////////////////////////////////////////////////////////////
  a_reset_clear: assert property ($fell(srst) |-> arr_ctl_q == '0 && !reg_mode_q)
    else $error("reset left drive or mode set");
  a_mode_enter: assert property (io_out_stb && io_addr == MODE_PORT |=> reg_mode_q)
    else $error("register mode not entered");
  a_mode_leave: assert property (io_in_stb && !io_out_stb && io_addr == MODE_PORT |=> !reg_mode_q)
    else $error("array mode not restored");
  a_mode_hold: assert property (!hit |=> $stable(reg_mode_q))
    else $error("mode changed without port command");
  a_op_onehot: assert property ($onehot0({arr_ctl_q.erase, arr_ctl_q.write, arr_ctl_q.flash_write}))
    else $error("two operations driven at once");
  a_erase_data: assert property (arr_ctl_q.erase |-> latched_write_data_q == ERASE_DATA)
    else $error("erase without all-ones data");
  a_write_seg: assert property (arr_ctl_q.write |-> arr_ctl_q.seg_en != '0)
    else $error("write with no segment enabled");
  a_abort_block: assert property (abort_execution |=> !drv)
    else $error("drive while aborted");
  a_write_normal: assert property (arr_ctl_q.write |-> arr_ctl_q.read_mode == EFPEC_READ_NORMAL)
    else $error("write driven under a margin read mode");
  a_latch_lock: assert property (drv ##1 drv |-> $stable(latched_write_address_q) && $stable(latched_write_data_q))
    else $error("latch moved while executing");
  a_seg_lock: assert property (drv ##1 drv |-> $stable(arr_ctl_q.seg_en) && $stable(arr_ctl_q.read_mode))
    else $error("segments or verify moved while executing");
  a_key_zero: assert property (rd_req && bus_req.addr[1:0] == REG_SEGMENT_CONTROL |-> ##2 bus_rdata_q[7:5] == 3'h0)
    else $error("key or reserved bits read nonzero");
  a_test_zero: assert property (rd_req && bus_req.addr[1:0] == REG_TEST_CONTROL |-> ##2 bus_rdata_q == 16'h0000)
    else $error("test register read nonzero");
endmodule : efpec_ctrl_asserts

bind efpec_ctrl efpec_ctrl_asserts #(.SEGS(SEGS)) u_asserts (
  .core_clk(core_clk), .srst(srst), .bus_req(bus_req), .io_out_stb(io_out_stb), .io_in_stb(io_in_stb),
  .io_addr(io_addr), .abort_execution(abort_execution), .arr_rdata(arr_rdata), .bus_rdata_q(bus_rdata_q),
  .reg_mode_q(reg_mode_q), .arr_ctl_q(arr_ctl_q), .arr_rd_q(arr_rd_q), .arr_addr_q(arr_addr_q),
  .latched_write_address_q(latched_write_address_q), .latched_write_data_q(latched_write_data_q));

// ===== test/efpec_array_model.sv
// array macro stand-in: data follows address
// assumes data is sampled only while arr_rd is high
module efpec_array_model
  import efpec_pkg::*;
(
  input  wire logic              arr_rd,
  input  wire logic [ADDR_W-1:0] arr_addr,
  output logic [DATA_W-1:0]      arr_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle shows the inverse so a stale sample is caught
  assign arr_rdata = arr_rd ? (arr_addr ^ 16'hA5C3) : ~(arr_addr ^ 16'hA5C3);
endmodule : efpec_array_model

// ===== test/efpec_ctrl_tb.sv
// self-checking bench for efpec_ctrl
// assumes the array stand-in and the bound checker
module efpec_ctrl_tb
  import efpec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              core_clk, srst, io_out_stb, io_in_stb, abort_execution, reg_mode_q, arr_rd_q;
  logic [15:0]       io_addr;
  efpec_bus_req_t    bus_req;
  efpec_array_ctl_t  arr_ctl_q;
  logic [DATA_W-1:0] arr_rdata, bus_rdata_q, latched_write_data_q;
  logic [ADDR_W-1:0] arr_addr_q, latched_write_address_q;
  int                mismatches, checked;
  logic [15:0]       t_data [8] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h00FF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
  logic [15:0]       t_word [8] = '{16'h0143, 16'h0145, 16'hFF47, 16'h0143, 16'h0123, 16'h0045, 16'h0141, 16'h0145};
  logic [2:0]        t_drv  [8] = '{3'h4, 3'h2, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
  efpec_ctrl dut (.core_clk(core_clk), .srst(srst), .bus_req(bus_req), .io_out_stb(io_out_stb),
    .io_in_stb(io_in_stb), .io_addr(io_addr), .abort_execution(abort_execution), .arr_rdata(arr_rdata),
    .bus_rdata_q(bus_rdata_q), .reg_mode_q(reg_mode_q), .arr_ctl_q(arr_ctl_q), .arr_rd_q(arr_rd_q),
    .arr_addr_q(arr_addr_q), .latched_write_address_q(latched_write_address_q),
    .latched_write_data_q(latched_write_data_q));
  efpec_array_model u_array (.arr_rd(arr_rd_q), .arr_addr(arr_addr_q), .arr_rdata(arr_rdata));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic bus(logic wr, logic [15:0] a, logic [15:0] d);
    @(posedge core_clk);
    #1;
    bus_req = '{sel: 1'b1, wr: wr, addr: a, wdata: d};
    @(posedge core_clk);
    #1;
    bus_req.sel = 1'b0;
  endtask : bus
  task automatic rd(logic [15:0] a, logic [15:0] exp, string name);
    bus(1'b0, a, 16'h0000);
    @(posedge core_clk);
    #1;
    chk(name, exp, bus_rdata_q);
  endtask : rd
  task automatic port(logic out, logic [15:0] a);
    @(posedge core_clk);
    #1;
    io_out_stb = out;
    io_in_stb = !out;
    io_addr = a;
    @(posedge core_clk);
    #1;
    io_out_stb = 1'b0;
    io_in_stb = 1'b0;
  endtask : port
  task automatic settle;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : settle
  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // whole run is about 5300 cycles, mostly the write pulse
  initial
  begin
    repeat (12000) @(posedge core_clk);
    mismatches++;
    test_done();
  end
  initial
  begin
    {srst, io_out_stb, io_in_stb, abort_execution, io_addr, bus_req} = {1'b1, 3'h0, 16'h0000, 34'h0};
    mismatches = 0;
    checked = 0;
    repeat (4) @(posedge core_clk);
    #1;
    srst = 1'b0;
    chk("mode", 16'h0000, 16'(reg_mode_q));
    bus(1'b1, 16'h1234, 16'hFFFF);
    chk("waddr", 16'h1234, latched_write_address_q);
    rd(16'h0040, 16'h0040 ^ 16'hA5C3, "array");
    port(1'b1, 16'hFF0E);
    chk("mode", 16'h0000, 16'(reg_mode_q));
    port(1'b1, MODE_PORT);
    chk("mode", 16'h0001, 16'(reg_mode_q));
    rd(16'h0000, 16'h0000, "segctl");
    bus(1'b1, 16'h0004, 16'hFFFE);
    rd(16'h0008, 16'hFF1E, "segctl");
    bus(1'b1, 16'h0106, 16'h2468);
    rd(16'h000A, 16'h2468, "waddr");
    bus(1'b1, 16'h0005, 16'h001F);
    rd(16'h0001, 16'h0000, "test");
    for (int v = 0; v < 4; v++)
    begin
      bus(1'b1, 16'h0000, {8'h01, 3'h0, 2'(v), 3'h0});
      settle();
      chk("verify", 16'(v), 16'(arr_ctl_q.read_mode));
    end
    // software keeps key and all-ones data itself
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, 16'h0003, t_data[i]);
      abort_execution = (i == 7);
      bus(1'b1, 16'h0000, t_word[i]);
      settle();
      chk("op", 16'(t_drv[i]), 16'({arr_ctl_q.erase, arr_ctl_q.write, arr_ctl_q.flash_write}));
      if (t_drv[i] != 3'h0)
      begin
        chk("seg", {8'h00, t_word[i][15:8]}, 16'(arr_ctl_q.seg_en));
        bus(1'b1, 16'h0000, t_word[i] ^ 16'h0218);
        bus(1'b1, 16'h0003, 16'h0000);
        settle();
        chk("seglock", {8'h00, t_word[i][15:8]}, 16'(arr_ctl_q.seg_en));
        rd(16'h0003, t_data[i], "wdata");
      end
      bus(1'b1, 16'h0000, 16'h0000);
      abort_execution = 1'b0;
    end
    // core-side erase flow; the 5 ms hold is the core timer's, far beyond this run
    bus(1'b1, 16'h0000, 16'h0143);
    settle();
    chk("erase", 16'h0004, 16'({arr_ctl_q.erase, arr_ctl_q.write, arr_ctl_q.flash_write}));
    bus(1'b1, 16'h0000, 16'h0000);
    bus(1'b1, 16'h0000, 16'h0108);
    port(1'b0, MODE_PORT);
    rd(16'h0000, 16'h0000 ^ 16'hA5C3, "ones");
    chk("verify", 16'(EFPEC_READ_ONES), 16'(arr_ctl_q.read_mode));
    port(1'b1, MODE_PORT);
    bus(1'b1, 16'h0000, 16'h0147);
    settle();
    chk("flash", 16'h0001, 16'({arr_ctl_q.erase, arr_ctl_q.write, arr_ctl_q.flash_write}));
    bus(1'b1, 16'h0000, 16'h0000);
    bus(1'b1, 16'h0000, 16'h0118);
    port(1'b0, MODE_PORT);
    for (int w = 0; w < DEPLETION_WORDS; w++)
      rd(16'(w), 16'(w) ^ 16'hA5C3, "depletion");
    // core-side write: at most eight zero bits, the rest masked as ones
    bus(1'b1, 16'h0040, 16'hFF5A);
    chk("wdata", 16'hFF5A, latched_write_data_q);
    port(1'b1, MODE_PORT);
    // model shows no depletion, so recovery pulses are skipped and stay under the cap
    chk("recovery", 16'h0000, 16'(arr_ctl_q.flash_write));
    bus(1'b1, 16'h0000, 16'h015D);
    settle();
    chk("write", 16'h0000, 16'({arr_ctl_q.erase, arr_ctl_q.write, arr_ctl_q.flash_write}));
    bus(1'b1, 16'h0000, 16'h0000);
    bus(1'b1, 16'h0000, 16'h0145);
    repeat (WRITE_PULSE_CYC) @(posedge core_clk);
    #1;
    chk("write", 16'h0002, 16'({arr_ctl_q.erase, arr_ctl_q.write, arr_ctl_q.flash_write}));
    chk("waddr", 16'h0040, latched_write_address_q);
    bus(1'b1, 16'h0000, 16'h0000);
    bus(1'b1, 16'h0000, 16'h0110);
    port(1'b0, MODE_PORT);
    rd(16'h0040, 16'h0040 ^ 16'hA5C3, "zeros");
    chk("verify", 16'(EFPEC_READ_ZEROS), 16'(arr_ctl_q.read_mode));
    port(1'b1, MODE_PORT);
    port(1'b0, MODE_PORT);
    chk("mode", 16'h0000, 16'(reg_mode_q));
    rd(16'h0041, 16'h0041 ^ 16'hA5C3, "array");
    test_done();
  end
endmodule : efpec_ctrl_tb
